// ### pkg/asr_pkg.sv
// Shared constants and types for the accelerometer status and offset register bank.
// Behaviour
// - axis results are signed bytes, reset zero
// - host writes to result bytes are ignored
// - status bit 0 flags a new result
// - status bit 1 flags result lost unread
// - status bit 2 flags trim parity, blocks self-test
// - level flags X/Y/Z in bits 7/6/5
// - pulse flags X/Y/Z in bits 4/3/2
// - pulse flags meaningless in double-pulse detection
// - bits 0/1 set by routed detection function
// - routing 00 level/pulse, 01 swapped, 10 single/any
// - clear bits drop irq flag and routed axis flags
// - address bit 7 writable, bits 6:0 read-only
// - disable bit set blocks two-wire access
// - user info byte from OTP, zero unprogrammed
// - identification byte loaded from OTP
// - offset trim subtracted from the measurement
// - 11-bit signed trim split low/high, reset zero
// - trim bit 0 weighs half an LSB
package asr_pkg;
    localparam int ASR_DATA_W = 8;
    localparam int ASR_ADDR_W = 8;
    localparam int ASR_TRIM_W = 11;
    localparam int ASR_TRIM_HI_W = 3;

    localparam logic [7:0] ASR_OFF_X_RESULT = 8'h06;
    localparam logic [7:0] ASR_OFF_Y_RESULT = 8'h07;
    localparam logic [7:0] ASR_OFF_Z_RESULT = 8'h08;
    localparam logic [7:0] ASR_OFF_STATUS = 8'h09;
    localparam logic [7:0] ASR_OFF_DETECT = 8'h0A;
    localparam logic [7:0] ASR_OFF_DEV_ADDR = 8'h0D;
    localparam logic [7:0] ASR_OFF_USER_INFO = 8'h0E;
    localparam logic [7:0] ASR_OFF_IDENT = 8'h0F;
    localparam logic [7:0] ASR_OFF_X_TRIM_LO = 8'h10;
    localparam logic [7:0] ASR_OFF_X_TRIM_HI = 8'h11;
    localparam logic [7:0] ASR_OFF_Y_TRIM_LO = 8'h12;
    localparam logic [7:0] ASR_OFF_Y_TRIM_HI = 8'h13;
    localparam logic [7:0] ASR_OFF_IRQ_CLEAR = 8'h17;

    localparam logic [7:0] ASR_RST_BYTE = 8'h00;
    localparam logic [6:0] ASR_BUS_DEVICE_ADDR = 7'h1D;
    localparam logic [10:0] ASR_RST_TRIM = 11'h000;

    localparam int ASR_BIT_READY = 0;
    localparam int ASR_BIT_OVERWRITE = 1;
    localparam int ASR_BIT_PARITY = 2;
    localparam int ASR_BIT_LEVEL_X = 7;
    localparam int ASR_BIT_PULSE_X = 4;
    localparam int ASR_BIT_FIRST_IRQ = 0;
    localparam int ASR_BIT_SECOND_IRQ = 1;
    localparam int ASR_BIT_TWO_WIRE_DIS = 7;
    localparam int ASR_BIT_CLR_FIRST = 0;
    localparam int ASR_BIT_CLR_SECOND = 1;

    localparam logic signed [10:0] ASR_SAT_MAX = 11'sh07F;
    localparam logic signed [10:0] ASR_SAT_MIN = -11'sh080;

    typedef enum logic [1:0] {
        ASR_ROUTE_LEVEL_PULSE = 2'b00,
        ASR_ROUTE_PULSE_LEVEL = 2'b01,
        ASR_ROUTE_SINGLE_ANY = 2'b10,
        ASR_ROUTE_RESERVED = 2'b11
    } asr_route_t;
endpackage : asr_pkg

// ### hdl/asr_axis_trim.sv
// Offset trim subtraction and saturation for one axis.
`timescale 1ns/1ns
module asr_axis_trim
    import asr_pkg::*;
(
    input wire logic [7:0] raw_sample, // signed measurement byte
    input wire logic [10:0] offset_trim, // signed trim, half-LSB units
    output logic [7:0] trimmed_sample // signed corrected byte
);
    logic signed [11:0] raw_half;
    logic signed [11:0] trim_ext;
    logic signed [11:0] diff_half;
    logic signed [10:0] diff_whole;

    always_comb begin
        raw_half = {{3{raw_sample[7]}}, raw_sample, 1'b0};
        trim_ext = {offset_trim[10], offset_trim};
        diff_half = raw_half - trim_ext;
        // arithmetic shift rounds toward minus infinity
        diff_whole = diff_half[11:1];
        if (diff_whole > ASR_SAT_MAX) begin
            trimmed_sample = 8'h7F;
        end else if (diff_whole < ASR_SAT_MIN) begin
            trimmed_sample = 8'h80;
        end else begin
            trimmed_sample = diff_whole[7:0];
        end
    end
endmodule : asr_axis_trim

// ### hdl/asr_detect_latch.sv
// Latched detection source flags with interrupt routing and clear.
`timescale 1ns/1ns
module asr_detect_latch
    import asr_pkg::*;
(
    input wire logic clk_sys, // system clock
    input wire logic reset_n, // sync reset, active low
    input wire logic [1:0] irq_function_routing, // routing field
    input wire logic [2:0] level_hit, // per-axis level events, x at bit 2
    input wire logic [2:0] pulse_hit, // per-axis single pulse events
    input wire logic double_pulse_hit, // double pulse event
    input wire logic clear_first_irq, // clear pulse for first flag
    input wire logic clear_second_irq, // clear pulse for second flag
    output logic [7:0] detect_flags // detection source byte
);
    logic [2:0] level_flags;
    logic [2:0] pulse_flags;
    logic first_irq_flag;
    logic second_irq_flag;
    logic [2:0] next_level_flags;
    logic [2:0] next_pulse_flags;
    logic next_first_irq_flag;
    logic next_second_irq_flag;
    logic first_event;
    logic second_event;
    logic first_is_level;
    logic second_is_level;
    logic any_level;
    logic any_single;
    asr_route_t route;

    always_comb begin
        route = asr_route_t'(irq_function_routing);
        any_level = |level_hit;
        any_single = |pulse_hit;
        // function assignment; reserved code acts as 00
        unique case (route)
            ASR_ROUTE_PULSE_LEVEL: begin
                first_event = any_single | double_pulse_hit;
                second_event = any_level;
                first_is_level = 1'b0;
                second_is_level = 1'b1;
            end
            ASR_ROUTE_SINGLE_ANY: begin
                first_event = any_single;
                second_event = any_single | double_pulse_hit;
                first_is_level = 1'b0;
                second_is_level = 1'b0;
            end
            ASR_ROUTE_LEVEL_PULSE, ASR_ROUTE_RESERVED: begin
                first_event = any_level;
                second_event = any_single | double_pulse_hit;
                first_is_level = 1'b1;
                second_is_level = 1'b0;
            end
        endcase
        next_level_flags = level_flags;
        next_pulse_flags = pulse_flags;
        next_first_irq_flag = first_irq_flag;
        next_second_irq_flag = second_irq_flag;
        // clear flag and its routed axis flags
        if (clear_first_irq) begin
            next_first_irq_flag = 1'b0;
            if (first_is_level) next_level_flags = 3'h0;
            else next_pulse_flags = 3'h0;
        end
        if (clear_second_irq) begin
            next_second_irq_flag = 1'b0;
            if (second_is_level) next_level_flags = 3'h0;
            else next_pulse_flags = 3'h0;
        end
        // level axis flags, set beats clear
        next_level_flags = next_level_flags | level_hit;
        // pulse axis flags, single pulse only
        next_pulse_flags = next_pulse_flags | pulse_hit;
        // routed irq flags, set beats clear
        next_first_irq_flag = next_first_irq_flag | first_event;
        next_second_irq_flag = next_second_irq_flag | second_event;
    end

    always_ff @(posedge clk_sys) begin
        if (!reset_n) begin
            level_flags <= 3'h0;
            pulse_flags <= 3'h0;
            first_irq_flag <= 1'b0;
            second_irq_flag <= 1'b0;
        end else begin
            level_flags <= next_level_flags;
            pulse_flags <= next_pulse_flags;
            first_irq_flag <= next_first_irq_flag;
            second_irq_flag <= next_second_irq_flag;
        end
    end

    assign detect_flags = {level_flags, pulse_flags, second_irq_flag, first_irq_flag};
endmodule : asr_detect_latch

// ### hdl/asr_regs.sv
// Top of the accelerometer status, detection and offset trim register bank.
`timescale 1ns/1ns
module asr_regs
    import asr_pkg::*;
(
    input wire logic clk_sys, // 125 MHz system clock
    input wire logic reset_n, // sync reset, active low
    input wire logic [7:0] reg_addr, // register address from serial front end
    input wire logic reg_wr, // write strobe, one cycle
    input wire logic reg_rd, // read strobe, one cycle
    input wire logic [7:0] reg_wdata, // write data
    input wire logic reg_two_wire, // access arrived over two-wire bus
    output logic [7:0] reg_rdata, // read data, held until next read
    output logic reg_rvalid, // read data valid pulse
    input wire logic sample_strobe, // new measurement set, one cycle
    input wire logic [7:0] x_raw_sample, // signed x measurement
    input wire logic [7:0] y_raw_sample, // signed y measurement
    input wire logic [7:0] z_raw_sample, // signed z measurement
    input wire logic trim_parity_fail, // trim data parity check failed
    input wire logic [2:0] level_hit, // level events, x at bit 2
    input wire logic [2:0] pulse_hit, // single pulse events, x at bit 2
    input wire logic double_pulse_hit, // double pulse event
    input wire logic [1:0] irq_function_routing, // irq routing field
    input wire logic ready_pin_suppress, // keep data-ready off first pin
    input wire logic otp_load, // OTP contents valid, one cycle
    input wire logic [7:0] otp_user_info, // OTP user information byte
    input wire logic [7:0] otp_part_id, // OTP identification byte
    output logic first_irq_pin, // first interrupt pin level
    output logic second_irq_pin, // second interrupt pin level
    output logic two_wire_enable, // two-wire interface allowed
    output logic self_test_allowed // self-test permitted
);
    logic [7:0] x_accel_result;
    logic [7:0] y_accel_result;
    logic [7:0] z_accel_result;
    logic result_available_flag;
    logic result_overwritten_flag;
    logic trim_parity_error_flag;
    logic [7:0] next_x_accel_result;
    logic [7:0] next_y_accel_result;
    logic [7:0] next_z_accel_result;
    logic next_result_available_flag;
    logic next_result_overwritten_flag;
    logic next_trim_parity_error_flag;

    logic two_wire_disable;
    logic [10:0] x_offset_trim;
    logic [10:0] y_offset_trim;
    logic [7:0] user_info_value;
    logic [7:0] part_identifier;
    logic next_two_wire_disable;
    logic [10:0] next_x_offset_trim;
    logic [10:0] next_y_offset_trim;
    logic [7:0] next_user_info_value;
    logic [7:0] next_part_identifier;

    logic [7:0] next_reg_rdata;
    logic next_reg_rvalid;
    logic next_first_irq_pin;
    logic next_second_irq_pin;
    logic next_two_wire_enable;
    logic next_self_test_allowed;

    logic access_ok;
    logic wr_hit;
    logic rd_hit;
    logic rd_result;
    logic rd_status;
    logic clear_first_irq;
    logic clear_second_irq;
    logic [7:0] detect_flags;
    logic [7:0] x_trimmed;
    logic [7:0] y_trimmed;
    logic [7:0] z_trimmed;
    logic [10:0] axis_trim [3];
    logic [7:0] axis_raw [3];
    logic [7:0] axis_trimmed [3];

    assign access_ok = !(reg_two_wire && two_wire_disable);
    assign wr_hit = reg_wr && access_ok;
    assign rd_hit = reg_rd && access_ok;
    assign rd_result = rd_hit && (reg_addr == ASR_OFF_X_RESULT || reg_addr == ASR_OFF_Y_RESULT
                                  || reg_addr == ASR_OFF_Z_RESULT);
    assign rd_status = rd_hit && (reg_addr == ASR_OFF_STATUS);
    // clear bits act on write, store nothing
    assign clear_first_irq = wr_hit && (reg_addr == ASR_OFF_IRQ_CLEAR) && reg_wdata[ASR_BIT_CLR_FIRST];
    assign clear_second_irq = wr_hit && (reg_addr == ASR_OFF_IRQ_CLEAR) && reg_wdata[ASR_BIT_CLR_SECOND];

    // z axis has no trim register, its trim is fixed at zero
    assign axis_trim[0] = x_offset_trim;
    assign axis_trim[1] = y_offset_trim;
    assign axis_trim[2] = ASR_RST_TRIM;
    assign axis_raw[0] = x_raw_sample;
    assign axis_raw[1] = y_raw_sample;
    assign axis_raw[2] = z_raw_sample;

    genvar gi;
    generate
        for (gi = 0; gi < 3; gi++) begin : g_axis
            asr_axis_trim u_trim (
                .raw_sample(axis_raw[gi]),
                .offset_trim(axis_trim[gi]),
                .trimmed_sample(axis_trimmed[gi])
            );
        end
    endgenerate

    assign x_trimmed = axis_trimmed[0];
    assign y_trimmed = axis_trimmed[1];
    assign z_trimmed = axis_trimmed[2];

    asr_detect_latch u_detect (
        .clk_sys(clk_sys),
        .reset_n(reset_n),
        .irq_function_routing(irq_function_routing),
        .level_hit(level_hit),
        .pulse_hit(pulse_hit),
        .double_pulse_hit(double_pulse_hit),
        .clear_first_irq(clear_first_irq),
        .clear_second_irq(clear_second_irq),
        .detect_flags(detect_flags)
    );

    // results and status flags
    always_comb begin
        next_x_accel_result = x_accel_result;
        next_y_accel_result = y_accel_result;
        next_z_accel_result = z_accel_result;
        next_result_available_flag = result_available_flag;
        next_result_overwritten_flag = result_overwritten_flag;
        // read clears, a same-cycle sample wins below
        if (rd_result) begin
            next_result_available_flag = 1'b0;
        end
        if (rd_status) begin
            next_result_overwritten_flag = 1'b0;
        end
        // results change only on a new sample
        if (sample_strobe) begin
            next_x_accel_result = x_trimmed;
            next_y_accel_result = y_trimmed;
            next_z_accel_result = z_trimmed;
            next_result_available_flag = 1'b1;
            if (result_available_flag) begin
                next_result_overwritten_flag = 1'b1;
            end
        end
        next_trim_parity_error_flag = trim_parity_error_flag | trim_parity_fail;
    end

    always_ff @(posedge clk_sys) begin
        if (!reset_n) begin
            x_accel_result <= ASR_RST_BYTE;
            y_accel_result <= ASR_RST_BYTE;
            z_accel_result <= ASR_RST_BYTE;
            result_available_flag <= 1'b0;
            result_overwritten_flag <= 1'b0;
            trim_parity_error_flag <= 1'b0;
        end else begin
            x_accel_result <= next_x_accel_result;
            y_accel_result <= next_y_accel_result;
            z_accel_result <= next_z_accel_result;
            result_available_flag <= next_result_available_flag;
            result_overwritten_flag <= next_result_overwritten_flag;
            trim_parity_error_flag <= next_trim_parity_error_flag;
        end
    end

    // host-written control and OTP copies
    always_comb begin
        next_two_wire_disable = two_wire_disable;
        next_x_offset_trim = x_offset_trim;
        next_y_offset_trim = y_offset_trim;
        next_user_info_value = user_info_value;
        next_part_identifier = part_identifier;
        if (wr_hit) begin
            unique case (reg_addr)
                // only bit 7 takes the write
                ASR_OFF_DEV_ADDR: next_two_wire_disable = reg_wdata[ASR_BIT_TWO_WIRE_DIS];
                // low byte and 3-bit high part
                ASR_OFF_X_TRIM_LO: next_x_offset_trim[7:0] = reg_wdata;
                ASR_OFF_X_TRIM_HI: next_x_offset_trim[10:8] = reg_wdata[ASR_TRIM_HI_W-1:0];
                ASR_OFF_Y_TRIM_LO: next_y_offset_trim[7:0] = reg_wdata;
                ASR_OFF_Y_TRIM_HI: next_y_offset_trim[10:8] = reg_wdata[ASR_TRIM_HI_W-1:0];
                default: begin
                end
            endcase
        end
        // bytes copied from OTP, zero until loaded
        if (otp_load) begin
            next_user_info_value = otp_user_info;
            next_part_identifier = otp_part_id;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (!reset_n) begin
            two_wire_disable <= 1'b0;
            x_offset_trim <= ASR_RST_TRIM;
            y_offset_trim <= ASR_RST_TRIM;
            user_info_value <= ASR_RST_BYTE;
            part_identifier <= ASR_RST_BYTE;
        end else begin
            two_wire_disable <= next_two_wire_disable;
            x_offset_trim <= next_x_offset_trim;
            y_offset_trim <= next_y_offset_trim;
            user_info_value <= next_user_info_value;
            part_identifier <= next_part_identifier;
        end
    end

    // read data and pin outputs
    always_comb begin
        next_reg_rdata = reg_rdata;
        next_reg_rvalid = rd_hit;
        if (rd_hit) begin
            unique case (reg_addr)
                ASR_OFF_X_RESULT: next_reg_rdata = x_accel_result;
                ASR_OFF_Y_RESULT: next_reg_rdata = y_accel_result;
                ASR_OFF_Z_RESULT: next_reg_rdata = z_accel_result;
                ASR_OFF_STATUS: next_reg_rdata = {5'h00, trim_parity_error_flag,
                                                  result_overwritten_flag, result_available_flag};
                ASR_OFF_DETECT: next_reg_rdata = detect_flags;
                // fixed device address below bit 7
                ASR_OFF_DEV_ADDR: next_reg_rdata = {two_wire_disable, ASR_BUS_DEVICE_ADDR};
                ASR_OFF_USER_INFO: next_reg_rdata = user_info_value;
                ASR_OFF_IDENT: next_reg_rdata = part_identifier;
                ASR_OFF_X_TRIM_LO: next_reg_rdata = x_offset_trim[7:0];
                ASR_OFF_X_TRIM_HI: next_reg_rdata = {5'h00, x_offset_trim[10:8]};
                ASR_OFF_Y_TRIM_LO: next_reg_rdata = y_offset_trim[7:0];
                ASR_OFF_Y_TRIM_HI: next_reg_rdata = {5'h00, y_offset_trim[10:8]};
                default: next_reg_rdata = 8'h00;
            endcase
        end
        // host picks data-ready on the first pin
        next_first_irq_pin = detect_flags[ASR_BIT_FIRST_IRQ]
                             | (result_available_flag & ~ready_pin_suppress);
        next_second_irq_pin = detect_flags[ASR_BIT_SECOND_IRQ];
        next_two_wire_enable = ~two_wire_disable;
        next_self_test_allowed = ~next_trim_parity_error_flag;
    end

    always_ff @(posedge clk_sys) begin
        if (!reset_n) begin
            reg_rdata <= 8'h00;
            reg_rvalid <= 1'b0;
            first_irq_pin <= 1'b0;
            second_irq_pin <= 1'b0;
            two_wire_enable <= 1'b1;
            self_test_allowed <= 1'b1;
        end else begin
            reg_rdata <= next_reg_rdata;
            reg_rvalid <= next_reg_rvalid;
            first_irq_pin <= next_first_irq_pin;
            second_irq_pin <= next_second_irq_pin;
            two_wire_enable <= next_two_wire_enable;
            self_test_allowed <= next_self_test_allowed;
        end
    end
endmodule : asr_regs

// ### verif/asr_regs_props.sv
// Checker on the register bank ports.
`timescale 1ns/1ns
module asr_regs_props
    import asr_pkg::*;
(
    input wire logic clk_sys, // clock
    input wire logic reset_n, // sync reset
    input wire logic [7:0] reg_addr, // address
    input wire logic reg_wr, // write strobe
    input wire logic reg_rd, // read strobe
    input wire logic [7:0] reg_wdata, // write data
    input wire logic reg_two_wire, // two-wire access
    input wire logic reg_rvalid, // read valid
    input wire logic sample_strobe, // new sample
    input wire logic trim_parity_fail, // parity fail
    input wire logic [2:0] level_hit, // level events
    input wire logic [2:0] pulse_hit, // pulse events
    input wire logic double_pulse_hit, // double pulse
    input wire logic [1:0] irq_function_routing, // routing
    input wire logic ready_pin_suppress, // ready off pin
    input wire logic first_irq_pin, // first pin
    input wire logic second_irq_pin, // second pin
    input wire logic two_wire_enable, // two-wire allowed
    input wire logic self_test_allowed // self-test allowed
);
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!reset_n);
    sequence s_clr_first;
        reg_wr && !reg_two_wire && reg_addr == ASR_OFF_IRQ_CLEAR && reg_wdata[ASR_BIT_CLR_FIRST];
    endsequence
    // no racing event, ready term masked
    sequence s_quiet;
        level_hit == 3'h0 && pulse_hit == 3'h0 && !double_pulse_hit && ready_pin_suppress;
    endsequence
    AST_RVALID_LAT: assert property (reg_rd && !reg_two_wire |=> reg_rvalid)
        else $error("read not answered");
    AST_RVALID_CAUSE: assert property (reg_rvalid |-> $past(reg_rd))
        else $error("read valid without read");
    AST_READY_PIN: assert property (sample_strobe ##1 !ready_pin_suppress |=> first_irq_pin)
        else $error("ready not on first pin");
    AST_PARITY_BLOCKS: assert property (trim_parity_fail |=> !self_test_allowed)
        else $error("self-test not blocked");
    AST_PARITY_CAUSE: assert property ($fell(self_test_allowed) |-> $past(trim_parity_fail))
        else $error("self-test blocked wrongly");
    AST_PARITY_STICKY: assert property (!self_test_allowed |=> !self_test_allowed)
        else $error("self-test block released");
    AST_TWO_WIRE_BIT: assert property (reg_wr && !reg_two_wire && reg_addr == ASR_OFF_DEV_ADDR ##1 !reg_wr
        |=> two_wire_enable == !$past(reg_wdata[7], 2)) else $error("two-wire enable wrong");
    AST_FIRST_LEVEL: assert property (irq_function_routing == 2'b00 && level_hit != 3'h0 ##1 !reg_wr
        |=> first_irq_pin) else $error("level not on first pin");
    AST_SECOND_SWAP: assert property (irq_function_routing == 2'b01 && level_hit != 3'h0 ##1 !reg_wr
        |=> second_irq_pin) else $error("level not on second pin");
    AST_SINGLE_ANY: assert property (irq_function_routing == 2'b10 && pulse_hit != 3'h0 ##1 !reg_wr
        |=> first_irq_pin && second_irq_pin) else $error("pulse not on both pins");
    AST_CLEAR_FIRST: assert property (s_clr_first ##0 s_quiet ##1 s_quiet |=> !first_irq_pin)
        else $error("first flag not cleared");
endmodule : asr_regs_props
bind asr_regs asr_regs_props u_props (.*);

// ### verif/asr_host_model.sv
// Host model: register port and routing controls.
`timescale 1ns/1ns
module asr_host_model
    import asr_pkg::*;
(
    input wire logic clk_sys, // clock
    output logic [7:0] reg_addr, // address
    output logic reg_wr, // write strobe
    output logic reg_rd, // read strobe
    output logic [7:0] reg_wdata, // write data
    output logic reg_two_wire, // two-wire access
    input wire logic [7:0] reg_rdata, // read data
    input wire logic reg_rvalid, // read valid
    output logic [1:0] irq_function_routing, // routing
    output logic ready_pin_suppress // ready off pin
);
    initial {reg_addr, reg_wr, reg_rd, reg_wdata, reg_two_wire, irq_function_routing, ready_pin_suppress} = '0;
    task automatic wr(input logic [7:0] a, input logic [7:0] dat, input logic tw);
        @(negedge clk_sys);
        {reg_addr, reg_wdata, reg_two_wire, reg_wr} = {a, dat, tw, 1'b1};
        @(negedge clk_sys);
        // released lines carry no stale value
        {reg_addr, reg_wdata, reg_wr} = {~a, ~dat, 1'b0};
    endtask : wr
    task automatic rd(input logic [7:0] a, input logic tw, output logic [7:0] dat, output logic ok);
        @(negedge clk_sys);
        {reg_addr, reg_two_wire, reg_rd} = {a, tw, 1'b1};
        @(negedge clk_sys);
        ok = reg_rvalid;
        dat = reg_rdata;
        {reg_addr, reg_rd} = {~a, 1'b0};
    endtask : rd
    task automatic clr(input logic [1:0] b);
        wr(ASR_OFF_IRQ_CLEAR, {6'h00, b}, 1'b0);
    endtask : clr
    task automatic cfg(input logic [1:0] r, input logic s);
        @(negedge clk_sys);
        {irq_function_routing, ready_pin_suppress} = {r, s};
    endtask : cfg
endmodule : asr_host_model

// ### verif/asr_regs_tb_top.sv
// Bench for the register bank.
`timescale 1ns/1ns
module asr_regs_tb_top
    import asr_pkg::*;
;
    localparam logic [7:0] OTP_ID = 8'hC3; // arbitrary value
    localparam logic [7:0] RO_ADDR [7] = '{ASR_OFF_X_RESULT, ASR_OFF_Y_RESULT, ASR_OFF_Z_RESULT,
        ASR_OFF_STATUS, ASR_OFF_DETECT, ASR_OFF_USER_INFO, ASR_OFF_IDENT};
    // route, level, pulse, double, source byte
    localparam logic [23:0] DET [6] = '{24'h040081, 24'h00200A, 24'h110022, 24'h104011, 24'h201007, 24'h200102};
    logic clk_sys = 1'b0;
    logic reset_n = 1'b0;
    logic [7:0] x_raw = '0, y_raw = '0, z_raw = '0, otp_ui = '0, otp_id = '0;
    logic [7:0] reg_addr, reg_wdata, reg_rdata, d;
    logic strobe = 1'b0, parity = 1'b0, dbl = 1'b0, otp_load = 1'b0;
    logic reg_wr, reg_rd, reg_two_wire, reg_rvalid, ok, pin1, pin2, tw_en, st_ok, ready_pin_suppress;
    logic [2:0] lvl = '0, pls = '0;
    logic [1:0] irq_function_routing;
    int fails = 0;
    int n_tests = 0;
    always #4 clk_sys = ~clk_sys;
    asr_host_model host (.*);
    asr_regs dut (.*, .sample_strobe(strobe), .x_raw_sample(x_raw), .y_raw_sample(y_raw), .z_raw_sample(z_raw),
        .trim_parity_fail(parity), .level_hit(lvl), .pulse_hit(pls), .double_pulse_hit(dbl),
        .otp_user_info(otp_ui), .otp_part_id(otp_id), .first_irq_pin(pin1), .second_irq_pin(pin2),
        .two_wire_enable(tw_en), .self_test_allowed(st_ok));
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        n_tests++;
        if (got !== exp) begin
            fails++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk
    task automatic rdc(input logic [7:0] a, input logic [7:0] exp);
        host.rd(a, 1'b0, d, ok);
        chk({7'h00, ok}, 8'h01);
        chk(d, exp);
    endtask : rdc
    // one-cycle sample strobe with x/y/z, or level/pulse/double events
    task automatic drive_ev(input logic s, input logic [23:0] xyz, input logic [6:0] ev);
        @(negedge clk_sys);
        {strobe, x_raw, y_raw, z_raw, lvl, pls, dbl} = {s, xyz, ev};
        @(negedge clk_sys);
        {strobe, lvl, pls, dbl} = 8'h00;
    endtask : drive_ev
    // floor half-LSB difference, clamp to a byte
    function automatic logic [7:0] expect_res(input logic [7:0] raw, input logic [10:0] trim);
        int v;
        v = (2 * int'($signed(raw)) - int'($signed(trim))) >>> 1;
        return (v > 127) ? 8'h7F : ((v < -128) ? 8'h80 : v[7:0]);
    endfunction : expect_res
    task automatic t_reset();
        for (int i = 6; i < 22; i++) rdc(i[7:0], (i == 13) ? {1'b0, ASR_BUS_DEVICE_ADDR} : 8'h00);
        chk({4'h0, pin1, pin2, tw_en, st_ok}, 8'h03);
    endtask : t_reset
    task automatic t_access();
        foreach (RO_ADDR[i]) host.wr(RO_ADDR[i], 8'hFF, 1'b0);
        foreach (RO_ADDR[i]) rdc(RO_ADDR[i], 8'h00);
        host.wr(ASR_OFF_DEV_ADDR, 8'hFF, 1'b0);
        rdc(ASR_OFF_DEV_ADDR, {1'b1, ASR_BUS_DEVICE_ADDR});
        chk({7'h00, tw_en}, 8'h00);
        host.wr(ASR_OFF_DEV_ADDR, 8'h00, 1'b1);
        host.rd(ASR_OFF_DEV_ADDR, 1'b1, d, ok);
        chk({7'h00, ok}, 8'h00);
        host.wr(ASR_OFF_DEV_ADDR, 8'h00, 1'b0);
        host.rd(ASR_OFF_DEV_ADDR, 1'b1, d, ok);
        chk(d, {1'b0, ASR_BUS_DEVICE_ADDR});
    endtask : t_access
    task automatic t_trim();
        host.wr(ASR_OFF_X_TRIM_LO, 8'h03, 1'b0);
        host.wr(ASR_OFF_X_TRIM_HI, 8'hF8, 1'b0);
        host.wr(ASR_OFF_Y_TRIM_HI, 8'hFC, 1'b0);
        rdc(ASR_OFF_X_TRIM_LO, 8'h03);
        rdc(ASR_OFF_X_TRIM_HI, 8'h00);
        rdc(ASR_OFF_Y_TRIM_HI, 8'h04);
        host.cfg(2'b00, 1'b0);
        drive_ev(1'b1, 24'h100080, 7'h00);
        @(negedge clk_sys);
        chk({7'h00, pin1}, 8'h01);
        host.cfg(2'b00, 1'b1);
        @(negedge clk_sys);
        chk({7'h00, pin1}, 8'h00);
        rdc(ASR_OFF_STATUS, 8'h01);
        rdc(ASR_OFF_X_RESULT, expect_res(8'h10, 11'h003));
        drive_ev(1'b1, 24'h00807F, 7'h00);
        drive_ev(1'b1, 24'h00807F, 7'h00);
        rdc(ASR_OFF_STATUS, 8'h03);
        rdc(ASR_OFF_STATUS, 8'h01);
        rdc(ASR_OFF_X_RESULT, expect_res(8'h00, 11'h003));
        rdc(ASR_OFF_Y_RESULT, expect_res(8'h80, 11'h400));
        rdc(ASR_OFF_Z_RESULT, 8'h7F);
        rdc(ASR_OFF_STATUS, 8'h00);
    endtask : t_trim
    task automatic t_detect();
        foreach (DET[i]) begin
            host.cfg(DET[i][21:20], 1'b1);
            drive_ev(1'b0, 24'h000000, {DET[i][18:16], DET[i][14:12], DET[i][8]});
            rdc(ASR_OFF_DETECT, DET[i][7:0]);
            chk({6'h00, pin2, pin1}, {6'h00, DET[i][1:0]});
            host.clr(2'b11);
            rdc(ASR_OFF_DETECT, 8'h00);
        end
        host.cfg(2'b00, 1'b1);
        drive_ev(1'b0, 24'h000000, 7'b1000100);
        host.clr(2'b01);
        rdc(ASR_OFF_DETECT, 8'h0A);
        host.clr(2'b10);
        rdc(ASR_OFF_DETECT, 8'h00);
    endtask : t_detect
    task automatic t_otp_parity();
        @(negedge clk_sys);
        {otp_load, otp_ui, otp_id} = {1'b1, 8'h5A, OTP_ID};
        @(negedge clk_sys);
        {otp_load, parity} = 2'b01;
        @(negedge clk_sys);
        parity = 1'b0;
        rdc(ASR_OFF_USER_INFO, 8'h5A);
        rdc(ASR_OFF_IDENT, OTP_ID);
        rdc(ASR_OFF_STATUS, 8'h04);
        chk({7'h00, st_ok}, 8'h00);
    endtask : t_otp_parity
    task automatic final_report();
        $display("comparisons %0d, mismatches %0d", n_tests, fails);
        if (fails == 0 && n_tests > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask : final_report
    initial begin
        repeat (12) @(negedge clk_sys);
        reset_n = 1'b1;
        t_reset();
        t_access();
        t_trim();
        t_detect();
        t_otp_parity();
        final_report();
    end
    initial begin
        #100000;
        fails++;
        final_report();
    end
endmodule : asr_regs_tb_top
